/* File: lcsd_dma.sv */
// three-channel linked cycle-steal dma with ahb-lite register slave
// assumes one slave on the bus, zero-wait bus side, memory side may wait, handshake by mem_ack
// Summary of operation
// - zero offsets and no window keep addresses fixed every transfer
// - cycle-steal moves one element per request then waits
// - linking requests the linked channel after every completed element
// - a linked request starts a channel without any hardware request
// - linked channel moves 16-bit words, destination stepping by two
// - destination window wraps modulo its size inside aligned block
// - cycle-steal on the linked channel gives one transfer per link
// - transmit channel runs until count zero, then drops hardware enable
// - without cycle-steal one request drains the whole count
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module lcsd_dma (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        converter_done_request,
	input  wire logic        serial_tx_empty_request,
	output logic             mem_req,
	output logic             mem_write,
	output logic [31:0]      mem_addr,
	output logic [1:0]       mem_size,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             irq
);
	logic [31:0] sar_q  [lcsd_pkg::NCH];
	logic [31:0] dar_q  [lcsd_pkg::NCH];
	logic [31:0] ctrl_q [lcsd_pkg::NCH];
	logic [23:0] bcr_q  [lcsd_pkg::NCH];
	logic [2:0]  active_q;
	logic [2:0]  status_q;
	logic [2:0]  mask_q;
	logic [2:0]  hw_prev_q;
	logic [1:0]  cur_q;
	logic        go_q;
	logic        wr_q;
	logic [7:0]  waddr_q;
	logic [31:0] hrdata_q;
	logic [2:0]  erq_vec;
	logic [2:0]  zero_vec;

	lcsd_xfer_if xf ();

	lcsd_engine u_eng (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.xf        (xf.eng),
		.mem_req   (mem_req),
		.mem_write (mem_write),
		.mem_addr  (mem_addr),
		.mem_size  (mem_size),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack)
	);

	// bus slave: zero wait, always okay
	wire        addr_ok   = hsel && hready && htrans[1];
	wire [1:0]  a_ch      = haddr[5:4];
	wire [1:0]  a_reg     = haddr[3:2];
	wire        a_chan    = (haddr[7:6] == 2'h0) && (a_ch != lcsd_pkg::GLB_SLOT);
	wire [31:0] chan_word = (a_reg == lcsd_pkg::REG_SAR) ? sar_q[a_ch] :
		(a_reg == lcsd_pkg::REG_DAR) ? dar_q[a_ch] :
		(a_reg == lcsd_pkg::REG_BCR) ? {8'h00, bcr_q[a_ch]} : ctrl_q[a_ch];
	wire [31:0] rd_word   = a_chan ? chan_word :
		(haddr[7:0] == lcsd_pkg::OFF_STATUS) ? {26'h0, active_q, status_q} :
		(haddr[7:0] == lcsd_pkg::OFF_MASK) ? {29'h0, mask_q} : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q     <= 1'b0;
			waddr_q  <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q <= addr_ok && hwrite;
			if (addr_ok)
			begin
				waddr_q  <= haddr[7:0];
				hrdata_q <= hwrite ? 32'h0000_0000 : rd_word;
			end
		end
	end

	// data-phase write decode
	wire [1:0] w_ch      = waddr_q[5:4];
	wire [1:0] w_reg     = waddr_q[3:2];
	wire       w_chan    = wr_q && (waddr_q[7:6] == 2'h0) && (w_ch != lcsd_pkg::GLB_SLOT);
	wire [2:0] w_sel     = w_chan ? (3'h1 << w_ch) : 3'h0;
	wire       wr_sar    = w_reg == lcsd_pkg::REG_SAR;
	wire       wr_dar    = w_reg == lcsd_pkg::REG_DAR;
	wire       wr_bcr    = w_reg == lcsd_pkg::REG_BCR;
	wire       wr_ctrl   = w_reg == lcsd_pkg::REG_CTRL;
	wire       wr_status = wr_q && (waddr_q == lcsd_pkg::OFF_STATUS);
	wire       wr_mask   = wr_q && (waddr_q == lcsd_pkg::OFF_MASK);
	wire [2:0] sw_start  = (wr_ctrl && hwdata[lcsd_pkg::CTL_START]) ? w_sel : 3'h0;

	// current channel view
	wire [31:0] cur_ctrl = ctrl_q[cur_q];
	wire [31:0] cur_sar  = sar_q[cur_q];
	wire [31:0] cur_dar  = dar_q[cur_q];
	wire [23:0] cur_bcr  = bcr_q[cur_q];
	wire [2:0]  step     = lcsd_pkg::size_step(cur_ctrl[lcsd_pkg::CTL_SIZE+:2]);
	wire [23:0] step_w   = {21'h0, step};
	wire        fin      = xf.done;
	wire [2:0]  fin_sel  = fin ? (3'h1 << cur_q) : 3'h0;
	wire [2:0]  own_sel  = (go_q || xf.busy || fin) ? (3'h1 << cur_q) : 3'h0;

	wire [23:0] bcr_nx   = (cur_bcr > step_w) ? cur_bcr - step_w : 24'h00_0000;
	wire        last     = (bcr_nx == 24'h00_0000);
	// step only when offset on, wrap inside window
	wire [31:0] sar_nx   = lcsd_pkg::wrap_next(cur_sar,
		cur_ctrl[lcsd_pkg::CTL_SINC] ? step : 3'h0, cur_ctrl[lcsd_pkg::CTL_SMOD+:4]);
	wire [31:0] dar_nx   = lcsd_pkg::wrap_next(cur_dar,
		cur_ctrl[lcsd_pkg::CTL_DINC] ? step : 3'h0, cur_ctrl[lcsd_pkg::CTL_DMOD+:4]);

	// link request to the chosen channel after each element
	wire [2:0] link_sel = (fin && cur_ctrl[lcsd_pkg::CTL_LINKEN]) ?
		(3'h1 << cur_ctrl[lcsd_pkg::CTL_LINKCH+:2]) : 3'h0;
	// one request per rising edge of a peripheral line
	wire [2:0] hw_req   = {serial_tx_empty_request, 1'b0, converter_done_request};
	wire [2:0] hw_edge  = hw_req & ~hw_prev_q & erq_vec;
	wire [2:0] req_set  = hw_edge | link_sel | sw_start;
	// cycle-steal ends the request per element, else at count zero
	wire [2:0] req_end  = (fin && (cur_ctrl[lcsd_pkg::CTL_CS] || last)) ? fin_sel : 3'h0;
	wire [2:0] req_clr  = req_end | (active_q & zero_vec & ~own_sel);
	wire [2:0] active_d = req_set | (active_q & ~req_clr);
	// done flag, set wins over write-one clear
	wire [2:0] done_set = last ? fin_sel : 3'h0;
	wire [2:0] status_d = done_set | (status_q & ~(wr_status ? hwdata[2:0] : 3'h0));

	// arbitration, lowest channel first
	wire [2:0] elig     = active_q & ~zero_vec;
	wire       free     = !xf.busy && !go_q && !fin;
	wire [1:0] pick     = elig[0] ? 2'h0 : elig[1] ? 2'h1 : 2'h2;

	assign xf.go   = go_q;
	assign xf.src  = cur_sar;
	assign xf.dst  = cur_dar;
	assign xf.size = cur_ctrl[lcsd_pkg::CTL_SIZE+:2];
	assign irq     = |(status_q & mask_q);

	always_comb
	begin
		for (int c = 0; c < lcsd_pkg::NCH; c++)
		begin
			erq_vec[c]  = ctrl_q[c][lcsd_pkg::CTL_ERQ];
			zero_vec[c] = (bcr_q[c] == 24'h00_0000);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			active_q  <= lcsd_pkg::RST_FLAGS;
			status_q  <= lcsd_pkg::RST_FLAGS;
			mask_q    <= lcsd_pkg::RST_FLAGS;
			hw_prev_q <= lcsd_pkg::RST_FLAGS;
			cur_q     <= 2'h0;
			go_q      <= 1'b0;
		end
		else
		begin
			active_q  <= active_d;
			status_q  <= status_d;
			hw_prev_q <= hw_req;
			if (wr_mask)
				mask_q <= hwdata[2:0];
			go_q <= free && (|elig);
			if (free && (|elig))
				cur_q <= pick;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int c = 0; c < lcsd_pkg::NCH; c++)
			begin
				sar_q[c]  <= lcsd_pkg::RST_ADDR;
				dar_q[c]  <= lcsd_pkg::RST_ADDR;
				bcr_q[c]  <= lcsd_pkg::RST_BCR;
				ctrl_q[c] <= lcsd_pkg::RST_CTRL;
			end
		end
		else
		begin
			for (int c = 0; c < lcsd_pkg::NCH; c++)
			begin
				if (w_sel[c] && wr_sar)
					sar_q[c] <= hwdata;
				else if (fin_sel[c])
					sar_q[c] <= sar_nx;
				if (w_sel[c] && wr_dar)
					dar_q[c] <= hwdata;
				else if (fin_sel[c])
					dar_q[c] <= dar_nx;
				if (w_sel[c] && wr_bcr)
					bcr_q[c] <= hwdata[23:0];
				else if (fin_sel[c])
					bcr_q[c] <= bcr_nx;
				if (w_sel[c] && wr_ctrl)
					ctrl_q[c] <= hwdata & lcsd_pkg::CTL_RW_MASK;
				// drop hardware enable at count zero
				else if (fin_sel[c] && last && cur_ctrl[lcsd_pkg::CTL_DREQ])
					ctrl_q[c][lcsd_pkg::CTL_ERQ] <= 1'b0;
			end
		end
	end

	// checks on hclk
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire no_sw_fix = !(wr_q && w_chan && w_ch == cur_q);
	wire [31:0] dwin = lcsd_pkg::wrap_mask(cur_ctrl[lcsd_pkg::CTL_DMOD+:4]);

	sequence elem_done;
		fin && no_sw_fix;
	endsequence

	fixed_addr_a: assert property (elem_done and (!cur_ctrl[lcsd_pkg::CTL_SINC]
		&& !cur_ctrl[lcsd_pkg::CTL_DINC]) |=> $stable(cur_sar) && $stable(cur_dar))
		else $error("fixed channel moved its address");
	steal_one_a: assert property (elem_done and (cur_ctrl[lcsd_pkg::CTL_CS]
		&& !req_set[cur_q]) |=> !active_q[cur_q])
		else $error("cycle-steal request stayed pending");
	link_req_a: assert property (fin && cur_ctrl[lcsd_pkg::CTL_LINKEN]
		|=> active_q[$past(cur_ctrl[lcsd_pkg::CTL_LINKCH+:2])])
		else $error("linked channel not requested");
	link_start_a: assert property (elem_done and (cur_ctrl[lcsd_pkg::CTL_LINKEN]
		&& !last) |-> ##[1:4] go_q)
		else $error("link request did not start a transfer");
	half_step_a: assert property (elem_done and (cur_ctrl[lcsd_pkg::CTL_DINC]
		&& cur_ctrl[lcsd_pkg::CTL_SIZE+:2] == lcsd_pkg::SZ_HALF)
		|=> (cur_dar & $past(dwin)) == (($past(cur_dar) + 32'h2) & $past(dwin)))
		else $error("halfword destination did not step by two");
	wrap_keep_a: assert property (elem_done
		|=> (cur_dar & ~$past(dwin)) == ($past(cur_dar) & ~$past(dwin)))
		else $error("destination left its window");
	tx_disable_a: assert property (elem_done and (last && cur_ctrl[lcsd_pkg::CTL_DREQ])
		|=> !cur_ctrl[lcsd_pkg::CTL_ERQ])
		else $error("hardware enable not dropped at count zero");
	burst_keep_a: assert property (elem_done and (!cur_ctrl[lcsd_pkg::CTL_CS] && !last)
		|=> active_q[cur_q] ##[1:3] go_q)
		else $error("burst stopped before count zero");
	count_done_a: assert property (elem_done and last
		|=> status_q[cur_q] && bcr_q[cur_q] == 24'h0 ##0 (irq || !mask_q[cur_q]))
		else $error("count zero did not flag done");
	sw_start_a: assert property (|sw_start
		|=> (active_q & $past(sw_start)) == $past(sw_start))
		else $error("start write did not request the channel");
endmodule : lcsd_dma

/* File: lcsd_engine.sv */
// element mover: one read from source then one write to destination
// assumes memory answers each request with a one-cycle mem_ack
module lcsd_engine (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	lcsd_xfer_if.eng         xf,
	output logic             mem_req,
	output logic             mem_write,
	output logic [31:0]      mem_addr,
	output logic [1:0]       mem_size,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack
);
	lcsd_pkg::lcsd_eng_t state_q;
	logic [31:0]         dst_q;
	logic                done_q;

	assign xf.busy = (state_q != lcsd_pkg::ENG_IDLE);
	assign xf.done = done_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q   <= lcsd_pkg::ENG_IDLE;
			dst_q     <= lcsd_pkg::RST_ADDR;
			done_q    <= 1'b0;
			mem_req   <= 1'b0;
			mem_write <= 1'b0;
			mem_addr  <= lcsd_pkg::RST_ADDR;
			mem_size  <= lcsd_pkg::SZ_BYTE;
			mem_wdata <= 32'h0000_0000;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				lcsd_pkg::ENG_IDLE:
					if (xf.go)
					begin
						mem_req   <= 1'b1;
						mem_write <= 1'b0;
						mem_addr  <= xf.src;
						mem_size  <= xf.size;
						dst_q     <= xf.dst;
						state_q   <= lcsd_pkg::ENG_READ;
					end
				lcsd_pkg::ENG_READ:
					if (mem_ack)
					begin
						mem_write <= 1'b1;
						mem_addr  <= dst_q;
						mem_wdata <= mem_rdata & lcsd_pkg::size_mask(mem_size);
						state_q   <= lcsd_pkg::ENG_WRITE;
					end
				lcsd_pkg::ENG_WRITE:
					if (mem_ack)
					begin
						mem_req   <= 1'b0;
						mem_write <= 1'b0;
						done_q    <= 1'b1;
						state_q   <= lcsd_pkg::ENG_IDLE;
					end
				default: state_q <= lcsd_pkg::ENG_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence read_granted;
		mem_req && !mem_write && mem_ack;
	endsequence
	sequence write_posted;
		mem_req && mem_write && (mem_addr == $past(dst_q));
	endsequence

	go_read_a: assert property (xf.go && !xf.busy |=> mem_req && !mem_write
		&& mem_addr == $past(xf.src))
		else $error("go did not start a source read");
	read_write_a: assert property (read_granted |=> write_posted)
		else $error("read was not followed by the destination write");
	write_done_a: assert property (mem_req && mem_write && mem_ack |=> xf.done && !mem_req)
		else $error("write ack did not finish the element");
endmodule : lcsd_engine

/* File: lcsd_mem_model.sv */
// memory and peripheral register model on the dma memory port
// assumes one request at a time, held by the dma until mem_ack
module lcsd_mem_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic [31:0]      mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] store [logic [31:0]];
	logic [31:0] rd_q;
	logic [1:0]  cnt_q;
	logic [1:0]  lim_q;

	// read data only valid in the ack cycle
	assign mem_rdata = mem_ack ? rd_q : ~rd_q;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mem_ack <= 1'b0;
			cnt_q <= 2'h0;
			lim_q <= 2'h0;
			rd_q <= 32'h0;
		end
		else if (mem_ack)
		begin
			mem_ack <= 1'b0;
			cnt_q <= 2'h0;
			lim_q <= slow ? lim_q + 2'h1 : 2'h0;
		end
		else if (mem_req)
		begin
			if (cnt_q == lim_q)
			begin
				mem_ack <= 1'b1;
				if (mem_write)
					store[mem_addr] = mem_wdata;
				else
					rd_q <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
			end
			else
				cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule : lcsd_mem_model

/* File: lcsd_pkg.sv */
// constants, field layout and helpers for the linked cycle-steal dma
// assumes a single hclk domain and 32-bit register words
package lcsd_pkg;
	localparam int          NCH         = 3;
	localparam int          BCR_W       = 24;
	localparam logic [1:0]  REG_SAR     = 2'h0;
	localparam logic [1:0]  REG_DAR     = 2'h1;
	localparam logic [1:0]  REG_BCR     = 2'h2;
	localparam logic [1:0]  REG_CTRL    = 2'h3;
	localparam logic [1:0]  GLB_SLOT    = 2'h3;
	localparam logic [7:0]  OFF_STATUS  = 8'h30;
	localparam logic [7:0]  OFF_MASK    = 8'h34;
	localparam int          CTL_ERQ     = 0;
	localparam int          CTL_CS      = 1;
	localparam int          CTL_SINC    = 2;
	localparam int          CTL_DINC    = 3;
	localparam int          CTL_SIZE    = 4;
	localparam int          CTL_SMOD    = 8;
	localparam int          CTL_DMOD    = 12;
	localparam int          CTL_LINKEN  = 16;
	localparam int          CTL_LINKCH  = 17;
	localparam int          CTL_DREQ    = 19;
	localparam int          CTL_START   = 31;
	localparam logic [31:0] CTL_RW_MASK = 32'h000f_ff3f;
	localparam logic [31:0] RST_ADDR    = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [23:0] RST_BCR     = 24'h00_0000;
	localparam logic [2:0]  RST_FLAGS   = 3'h0;
	localparam logic [1:0]  SZ_BYTE     = 2'h0;
	localparam logic [1:0]  SZ_HALF     = 2'h1;
	localparam logic [1:0]  SZ_WORD     = 2'h2;
	localparam logic [31:0] MOD_BASE    = 32'h0000_0008;

	typedef enum logic [2:0] {
		ENG_IDLE  = 3'b001,
		ENG_READ  = 3'b010,
		ENG_WRITE = 3'b100
	} lcsd_eng_t;

	function automatic logic [2:0] size_step(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: size_step = 3'h1;
			SZ_HALF: size_step = 3'h2;
			default: size_step = 3'h4;
		endcase
	endfunction : size_step

	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: size_mask = 32'h0000_00ff;
			SZ_HALF: size_mask = 32'h0000_ffff;
			default: size_mask = 32'hffff_ffff;
		endcase
	endfunction : size_mask

	// window of 2^(mod+3) bytes, mod 0 means no window
	function automatic logic [31:0] wrap_mask(input logic [3:0] md);
		wrap_mask = (md == 4'h0) ? 32'hffff_ffff : (MOD_BASE << md) - 32'h1;
	endfunction : wrap_mask

	function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [2:0] st,
		input logic [3:0] md);
		logic [31:0] m;
		logic [31:0] n;
		m = wrap_mask(md);
		n = a + {29'h0, st};
		wrap_next = (a & ~m) | (n & m);
	endfunction : wrap_next
endpackage : lcsd_pkg

/* File: lcsd_xfer_if.sv */
// one element transfer order from the channel logic to the mover
// assumes both ends on hclk
interface lcsd_xfer_if;
	logic        go;
	logic [31:0] src;
	logic [31:0] dst;
	logic [1:0]  size;
	logic        busy;
	logic        done;
	modport ctrl (output go, output src, output dst, output size, input busy, input done);
	modport eng  (input go, input src, input dst, input size, output busy, output done);
endinterface : lcsd_xfer_if

/* File: test_linked_cycle_steal_dma.sv */
// self-checking bench for the linked cycle-steal dma
// assumes lcsd_pkg, lcsd_xfer_if, lcsd_engine and lcsd_mem_model compiled first
module test_linked_cycle_steal_dma;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, slow;
	logic        converter_done_request, serial_tx_empty_request;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, seed, v;
	logic [31:0] b [4];
	logic        hreadyout, hresp, irq, mem_req, mem_write, mem_ack;
	logic [1:0]  mem_size;
	logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] wr_addr [$];
	logic [31:0] wr_data [$];
	logic [1:0]  wr_size [$];
	int          fails, num_checks;

	lcsd_dma u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.converter_done_request(converter_done_request),
		.serial_tx_empty_request(serial_tx_empty_request), .mem_req(mem_req),
		.mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));

	lcsd_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_req(mem_req),
		.mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));

	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// log every completed memory write
	always @(posedge hclk)
		if (hresetn && mem_req && mem_ack && mem_write)
		begin
			wr_addr.push_back(mem_addr);
			wr_data.push_back(mem_wdata);
			wr_size.push_back(mem_size);
		end

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// ring slot of element k in the 128-byte window at 0x3000
	function automatic logic [31:0] ring_addr(input int k);
		return 32'h3000 | ((32'h70 + 32'(2 * k)) & 32'h7f);
	endfunction : ring_addr

	task test_done();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic bus_wait();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				fails++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask : bus_wait

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		bus_wait();
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rdc

	task automatic pulse(input int ch);
		wr_addr.delete();
		wr_data.delete();
		wr_size.delete();
		@(posedge hclk);
		if (ch == 0)
			converter_done_request <= 1'b1;
		else
			serial_tx_empty_request <= 1'b1;
		@(posedge hclk);
		converter_done_request <= 1'b0;
		serial_tx_empty_request <= 1'b0;
	endtask : pulse

	task automatic wait_wr(input int n);
		int i;
		i = 0;
		while (wr_addr.size() < n)
		begin
			i++;
			if (i > 300)
			begin
				fails++;
				test_done();
			end
			@(posedge hclk);
		end
		repeat (20) @(posedge hclk);
		chk(32'(wr_addr.size()), 32'(n));
	endtask : wait_wr

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		converter_done_request = 1'b0;
		serial_tx_empty_request = 1'b0;
		slow = 1'b0;
		seed = 32'd70869;
		fails = 0;
		num_checks = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk({29'h0, hreadyout, hresp, irq}, 32'h4);
		rdc(32'h0c, lcsd_pkg::RST_CTRL);
		rdc(32'h08, {8'h0, lcsd_pkg::RST_BCR});
		wr(32'h38, 32'hffff_ffff);
		rdc(32'h38, 32'h0);
		wr(32'h00, 32'h1000);
		wr(32'h04, 32'h2000);
		wr(32'h08, 32'h18);
		wr(32'h0c, 32'h0003_0013);
		rdc(32'h0c, 32'h0003_0013);
		// window array aligned to 128 bytes
		wr(32'h10, 32'h2000);
		wr(32'h14, 32'h3070);
		wr(32'h18, 32'h18);
		wr(32'h1c, 32'h0000_401a);
		for (int k = 0; k < 12; k++)
		begin
			v = xs() & 32'hffff;
			slow <= v[3];
			u_mem.store[32'h1000] = v;
			pulse(0);
			wait_wr(2);
			chk(wr_addr[0], 32'h2000);
			chk(wr_data[0], v);
			chk(wr_addr[1], ring_addr(k));
			chk(wr_data[1], v);
			chk({30'h0, wr_size[1]}, {30'h0, lcsd_pkg::SZ_HALF});
		end
		rdc(32'h30, 32'h3);
		rdc(32'h08, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(32'h34, 32'h3);
		@(posedge hclk);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr(32'h30, 32'h1);
		rdc(32'h30, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(32'h30, 32'h2);
		@(posedge hclk);
		#1;
		chk({31'h0, irq}, 32'h0);
		pulse(0);
		wait_wr(0);
		for (int i = 0; i < 4; i++)
		begin
			b[i] = xs() & 32'hff;
			u_mem.store[32'h4000 + 32'(i)] = b[i];
		end
		wr(32'h20, 32'h4000);
		wr(32'h24, 32'h5000);
		wr(32'h28, 32'h4);
		wr(32'h2c, 32'h0008_0007);
		for (int i = 0; i < 4; i++)
		begin
			pulse(1);
			wait_wr(1);
			chk(wr_addr[0], 32'h5000);
			chk(wr_data[0], b[i]);
		end
		rdc(32'h2c, 32'h0008_0006);
		pulse(1);
		wait_wr(0);
		rdc(32'h30, 32'h4);
		wr(32'h20, 32'h4000);
		wr(32'h28, 32'h3);
		wr(32'h2c, 32'h0000_0005);
		pulse(1);
		wait_wr(3);
		for (int i = 0; i < 3; i++)
			chk(wr_data[i], b[i]);
		// software start, word size, 16-byte source window
		b[0] = xs();
		b[1] = xs();
		u_mem.store[32'h600c] = b[0];
		u_mem.store[32'h6000] = b[1];
		wr(32'h10, 32'h600c);
		wr(32'h14, 32'h7000);
		wr(32'h18, 32'h8);
		wr_addr.delete();
		wr_data.delete();
		wr_size.delete();
		wr(32'h1c, 32'h8000_012c);
		wait_wr(2);
		chk(wr_data[0], b[0]);
		chk(wr_data[1], b[1]);
		chk(wr_addr[1], 32'h7004);
		chk({30'h0, wr_size[0]}, {30'h0, lcsd_pkg::SZ_WORD});
		rdc(32'h1c, 32'h0000_012c);
		rdc(32'h30, 32'h6);
		chk({31'h0, irq}, 32'h1);
		test_done();
	end
endmodule : test_linked_cycle_steal_dma
